// *** rtl/rctco_fifo.sv ***
// module: small synchronous valid/ready fifo
`timescale 1ns/100ps
module rctco_fifo
   import rctco_pkg::*;
#(
   parameter int W = 8,                // word width
   parameter int D = 8                 // depth, power of two
)(
   input  wire logic         clk_sys,   // system clock
   input  wire logic         resetn,    // sync reset, low active
   input  wire logic [W-1:0] in_data,   // word from source
   input  wire logic         in_valid,  // source offers word
   output logic              in_ready,  // room for a word
   output logic [W-1:0]      out_data,  // head word
   output logic              out_valid, // head word present
   input  wire logic         out_ready  // sink takes head
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;

   // ==========================================================
   // status: extra pointer bit tells full from empty
   assign in_ready  = (wr_q[AW] == rd_q[AW])
                      || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem_q[rd_q[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage, no reset needed on data
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_q[wr_q[AW-1:0]] <= in_data;
   end

   // pointers
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_q + (AW+1)'(push);
         rd_q <= rd_q + (AW+1)'(pop);
      end
   end
endmodule // rctco_fifo

// *** rtl/rctco_pkg.sv ***
// package: constants for the receive channel timing and clock outputs
package rctco_pkg;
   // ==========================================================
   // port and frame geometry
   localparam int          NUM_PORTS   = 8;
   localparam int          BITS_PER_CH = 8;
   localparam logic [2:0]  LSB_BIT     = 3'h7;   // last bit time of a channel
   localparam logic [2:0]  FIRST_BIT   = 3'h0;
   localparam logic [4:0]  T1_LAST_CH  = 5'h17;  // 24 channels
   localparam logic [4:0]  E1_LAST_CH  = 5'h1f;  // 32 channels
   localparam logic [4:0]  FIRST_CH    = 5'h00;
   localparam int          SIG_W       = 8;
   localparam int          FIFO_DEPTH  = 8;
   // ==========================================================
   // clock synthesis
   localparam longint      CLK_HZ      = 200_000_000;
   localparam int          PH_W        = 32;
   localparam logic [31:0] PH_ZERO     = 32'h0000_0000;
   function automatic logic [31:0] nco_inc(input longint hz);
      return 32'((hz << PH_W) / CLK_HZ);
   endfunction
   localparam logic [31:0] INC_64K   = nco_inc(64_000);
   localparam logic [31:0] INC_256K  = nco_inc(256_000);
   localparam logic [31:0] INC_1M544 = nco_inc(1_544_000);
   localparam logic [31:0] INC_2M048 = nco_inc(2_048_000);
   localparam logic [31:0] INC_4M096 = nco_inc(4_096_000);
   localparam logic [31:0] INC_8M192 = nco_inc(8_192_000);
   localparam logic [31:0] INC_12M288 = nco_inc(12_288_000);
   localparam logic [31:0] INC_16M384 = nco_inc(16_384_000);
   // ==========================================================
   // transmit clock loss: three nominal 1.544 MHz periods
   localparam int          TX_PERIOD_PS = 648_000 / 1000 * 1000;
   localparam int          CLK_PERIOD_PS = 5000;
   localparam logic [9:0]  LTC_CYCLES   =
      10'((3 * TX_PERIOD_PS) / CLK_PERIOD_PS);
   localparam logic [9:0]  LTC_ZERO     = 10'h000;
   localparam logic [9:0]  LTC_ONE      = 10'h001;
   // ==========================================================
   // selections
   typedef enum logic [1:0] {
      BP_2M048, BP_4M096, BP_8M192, BP_16M384 } rctco_bp_freq_t;
   typedef enum logic [1:0] {
      REF_LINE, REF_MCLK_T1, REF_MCLK_E1, REF_EXT } rctco_bp_ref_t;
   typedef enum logic [2:0] {
      CO_1M544, CO_2M048, CO_4M096, CO_8M192,
      CO_12M288, CO_16M384, CO_256K, CO_64K } rctco_co_freq_t;
   typedef enum logic {
      FN_LOSS_FRAME, FN_LOSS_TXCLK } rctco_pin_fn_t;
endpackage : rctco_pkg

// *** rtl/rctco_port.sv ***
// module: per-port receive channel timing (signaling, mask, channel clock)
`timescale 1ns/100ps
module rctco_port
   import rctco_pkg::*;
(
   input  wire logic             clk_sys,     // system clock
   input  wire logic             resetn,      // sync reset, low active
   input  wire logic             line_clk,    // recovered line clock
   input  wire logic             sys_clk,     // receive system clock
   input  wire logic             es_en,       // elastic store on
   input  wire logic             e1_mode,     // 32 channels when high
   input  wire logic             frame_start, // tick is ch0 bit0
   input  wire logic             chclk_sel,   // pin shows channel clock
   input  wire logic [31:0]      block_mask,  // per-channel mask level
   input  wire logic [SIG_W-1:0] sig_data,    // head signaling word
   input  wire logic             sig_valid,   // head word present
   output logic                  sig_pop,     // take head word
   output logic                  sig_out,     // serial signaling
   output logic                  timing_pin   // mask or channel clock
);
   logic       tclk_prev_q;
   logic       tclk;
   logic       tick;
   logic [2:0] bit_q;
   logic [4:0] ch_q;
   logic [2:0] bit_d;
   logic [4:0] ch_d;
   logic       chclk_d;
   logic       blk_d;
   logic [SIG_W-1:0] sh_q;

   // ==========================================================
   // timing clock choice and its rising edge
   assign tclk = es_en ? sys_clk : line_clk;
   assign tick = tclk & ~tclk_prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) tclk_prev_q <= 1'b0;
      else         tclk_prev_q <= tclk;
   end

   // next bit and channel position
   always_comb
   begin
      bit_d = bit_q + 3'h1;
      ch_d  = ch_q;
      if (frame_start)
      begin
         bit_d = FIRST_BIT;
         ch_d  = FIRST_CH;
      end
      else if (bit_q == LSB_BIT)
         ch_d = (ch_q == (e1_mode ? E1_LAST_CH : T1_LAST_CH)) ? FIRST_CH
                : ch_q + 5'h01;
   end
   assign chclk_d = (bit_d == LSB_BIT);
   assign blk_d   = block_mask[ch_d];
   assign sig_pop = tick & (bit_d == FIRST_BIT) & sig_valid;

   // counters, pin and signaling move only on timing edges
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         bit_q      <= LSB_BIT;
         ch_q       <= FIRST_CH;
         timing_pin <= 1'b0;
         sig_out    <= 1'b0;
         sh_q       <= '0;
      end
      else if (tick)
      begin
         bit_q      <= bit_d;
         ch_q       <= ch_d;
         timing_pin <= chclk_sel ? chclk_d : blk_d;
         if (bit_d == FIRST_BIT)
         begin
            // empty fifo gives idle zero signaling for the channel
            sh_q    <= sig_valid ? sig_data : '0;
            sig_out <= sig_valid ? sig_data[SIG_W-1] : 1'b0;
         end
         else
         begin
            sh_q    <= {sh_q[SIG_W-2:0], 1'b0};
            sig_out <= sh_q[SIG_W-2];
         end
      end
   end

   // ==========================================================
   // checks
   pin_only_tick_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      !tick |=> $stable(timing_pin))
      else $error("timing pin moved without timing edge");
   chclk_lsb_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      tick && chclk_sel && (bit_d == LSB_BIT) |=> timing_pin)
      else $error("channel clock not high in lsb");
   chclk_width_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      tick && chclk_sel && !frame_start && (bit_q == LSB_BIT)
      |=> !timing_pin)
      else $error("channel clock longer than one period");
   mask_follow_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      tick && !chclk_sel |=> timing_pin == $past(block_mask[ch_d]))
      else $error("mask pin wrong for channel");
   ch_wrap_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      !e1_mode |-> ch_q <= T1_LAST_CH)
      else $error("t1 channel count exceeded");
endmodule // rctco_port

// *** rtl/rctco_top.sv ***
// module: receive channel timing and shared clock outputs, top level
`timescale 1ns/100ps
module rctco_top
   import rctco_pkg::*;
(
   input  wire logic                  clk_sys,            // 200 MHz clock
   input  wire logic                  resetn,             // sync reset, low
   // per-port receive timing
   input  wire logic [NUM_PORTS-1:0]  rx_recovered_line_clock, // line clk
   input  wire logic [NUM_PORTS-1:0]  rx_system_clock,    // system clk
   input  wire logic [NUM_PORTS-1:0]  rx_es_enable,       // store on
   input  wire logic [NUM_PORTS-1:0]  rx_e1_mode,         // e1 framing
   input  wire logic [NUM_PORTS-1:0]  rx_frame_start,     // ch0 bit0 mark
   input  wire logic [NUM_PORTS-1:0]  rx_chclk_select,    // pin function
   input  wire logic [NUM_PORTS-1:0][31:0] rx_block_mask, // mask bits
   // per-port signaling words from the framer
   input  wire logic [NUM_PORTS-1:0][SIG_W-1:0] sig_in_data, // word
   input  wire logic [NUM_PORTS-1:0]  sig_in_valid,       // word offered
   output logic      [NUM_PORTS-1:0]  sig_in_ready,       // room in fifo
   output logic      [NUM_PORTS-1:0]  rx_signaling_out,   // serial out
   output logic      [NUM_PORTS-1:0]  rx_channel_timing,  // mask or clock
   // backplane clock
   input  wire logic [1:0]            bp_freq_select,     // output rate
   input  wire logic [1:0]            bp_ref_select,      // reference kind
   input  wire logic [2:0]            bp_ref_port,        // line clock port
   input  wire logic                  external_reference_clock, // ext ref
   output logic                       backplane_clock_out, // bp clock
   // general clock and loss pin
   input  wire logic [2:0]            clock_out_freq_select, // rate
   input  wire logic                  eight_port_mode_bit, // loss pin on
   input  wire logic                  loss_pin_function,  // 1: tx clock
   input  wire logic                  rx_frame_searching, // sync hunting
   input  wire logic                  tx_line_clock_in,   // port 1 tx clk
   output logic                       general_clock_out   // shared pin
);
   // ==========================================================
   // per-port signaling fifos and channel timing
   logic [NUM_PORTS-1:0][SIG_W-1:0] fifo_data;
   logic [NUM_PORTS-1:0]            fifo_valid;
   logic [NUM_PORTS-1:0]            fifo_pop;

   // fifo ready goes straight back, so a slow port throttles its framer
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++)
      begin : g_port
         rctco_fifo #(
            .W (SIG_W),
            .D (FIFO_DEPTH)
         ) u_fifo (
            .clk_sys   (clk_sys),
            .resetn    (resetn),
            .in_data   (sig_in_data[gp]),
            .in_valid  (sig_in_valid[gp]),
            .in_ready  (sig_in_ready[gp]),
            .out_data  (fifo_data[gp]),
            .out_valid (fifo_valid[gp]),
            .out_ready (fifo_pop[gp])
         );
         rctco_port u_port (
            .clk_sys     (clk_sys),
            .resetn      (resetn),
            .line_clk    (rx_recovered_line_clock[gp]),
            .sys_clk     (rx_system_clock[gp]),
            .es_en       (rx_es_enable[gp]),
            .e1_mode     (rx_e1_mode[gp]),
            .frame_start (rx_frame_start[gp]),
            .chclk_sel   (rx_chclk_select[gp]),
            .block_mask  (rx_block_mask[gp]),
            .sig_data    (fifo_data[gp]),
            .sig_valid   (fifo_valid[gp]),
            .sig_pop     (fifo_pop[gp]),
            .sig_out     (rx_signaling_out[gp]),
            .timing_pin  (rx_channel_timing[gp])
         );
      end
   endgenerate

   // ==========================================================
   // master-clock derived reference (1.544 or 2.048 MHz)
   logic [PH_W-1:0] mref_ph_q;
   logic [PH_W-1:0] mref_inc;

   assign mref_inc = (bp_ref_select == REF_MCLK_T1) ? INC_1M544
                     : INC_2M048;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) mref_ph_q <= PH_ZERO;
      else         mref_ph_q <= mref_ph_q + mref_inc;
   end

   // ==========================================================
   // backplane clock reference choice and its rising edge
   logic ref_lvl;
   logic ref_prev_q;
   logic ref_rise;

   always_comb
   begin
      unique case (rctco_bp_ref_t'(bp_ref_select))
         REF_LINE:    ref_lvl = rx_recovered_line_clock[bp_ref_port];
         REF_MCLK_T1: ref_lvl = mref_ph_q[PH_W-1];
         REF_MCLK_E1: ref_lvl = mref_ph_q[PH_W-1];
         REF_EXT:     ref_lvl = external_reference_clock;
      endcase
   end
   assign ref_rise = ref_lvl & ~ref_prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) ref_prev_q <= 1'b0;
      else         ref_prev_q <= ref_lvl;
   end

   // ==========================================================
   // backplane clock synthesis
   logic [PH_W-1:0] bp_ph_q;
   logic [PH_W-1:0] bp_inc;

   always_comb
   begin
      unique case (rctco_bp_freq_t'(bp_freq_select))
         BP_2M048:  bp_inc = INC_2M048;
         BP_4M096:  bp_inc = INC_4M096;
         BP_8M192:  bp_inc = INC_8M192;
         BP_16M384: bp_inc = INC_16M384;
      endcase
   end

   // phase snaps to zero on each reference rising edge; a 200 MHz phase
   // accumulator gives the average rate with up to 5 ns of edge jitter
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         bp_ph_q <= PH_ZERO;
      else if (ref_rise)
         bp_ph_q <= PH_ZERO;
      else
         bp_ph_q <= bp_ph_q + bp_inc;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) backplane_clock_out <= 1'b0;
      else         backplane_clock_out <= bp_ph_q[PH_W-1];
   end

   // ==========================================================
   // general clock synthesis from the master clock
   logic [PH_W-1:0] co_ph_q;
   logic [PH_W-1:0] co_inc;

   always_comb
   begin
      unique case (rctco_co_freq_t'(clock_out_freq_select))
         CO_1M544:  co_inc = INC_1M544;
         CO_2M048:  co_inc = INC_2M048;
         CO_4M096:  co_inc = INC_4M096;
         CO_8M192:  co_inc = INC_8M192;
         CO_12M288: co_inc = INC_12M288;
         CO_16M384: co_inc = INC_16M384;
         CO_256K:   co_inc = INC_256K;
         CO_64K:    co_inc = INC_64K;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) co_ph_q <= PH_ZERO;
      else         co_ph_q <= co_ph_q + co_inc;
   end

   // ==========================================================
   // transmit clock activity monitor for port 1
   logic       txc_prev_q;
   logic       txc_toggle;
   logic [9:0] idle_cnt_q;
   logic       tx_loss_q;

   assign txc_toggle = tx_line_clock_in ^ txc_prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) txc_prev_q <= 1'b0;
      else         txc_prev_q <= tx_line_clock_in;
   end

   // idle count saturates so a dead clock keeps the flag up
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         idle_cnt_q <= LTC_ZERO;
      else if (txc_toggle)
         idle_cnt_q <= LTC_ZERO;
      else if (idle_cnt_q != LTC_CYCLES)
         idle_cnt_q <= idle_cnt_q + LTC_ONE;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn) tx_loss_q <= 1'b0;
      else         tx_loss_q <= (idle_cnt_q == LTC_CYCLES) & ~txc_toggle;
   end

   // ==========================================================
   // shared pin: general clock, or loss indication in eight-port mode
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         general_clock_out <= 1'b0;
      else if (!eight_port_mode_bit)
         general_clock_out <= co_ph_q[PH_W-1];
      else if (rctco_pin_fn_t'(loss_pin_function) == FN_LOSS_TXCLK)
         general_clock_out <= tx_loss_q;
      else
         general_clock_out <= rx_frame_searching;
   end

   // ==========================================================
   // checks
   gen_clock_pin_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      !eight_port_mode_bit |=> general_clock_out == $past(co_ph_q[PH_W-1]))
      else $error("general clock not on shared pin");
   lof_pin_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      eight_port_mode_bit && !loss_pin_function && rx_frame_searching
      |=> general_clock_out)
      else $error("loss of frame not shown");
   ltc_raise_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      (idle_cnt_q == LTC_CYCLES) && !txc_toggle |=> tx_loss_q)
      else $error("tx clock loss not raised");
   ltc_clear_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      txc_toggle |=> !tx_loss_q ##1 !tx_loss_q)
      else $error("tx clock loss held after toggle");
   ltc_pin_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      eight_port_mode_bit && loss_pin_function
      |=> general_clock_out == $past(tx_loss_q))
      else $error("tx clock loss not on pin");
   bp_snap_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      ref_rise |=> bp_ph_q == PH_ZERO ##1 bp_ph_q == $past(bp_inc))
      else $error("backplane phase not aligned to reference");
   // the step is the increment chosen one cycle back; the edge that
   // leaves reset is skipped since the phase was cleared there
   bp_rate_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      resetn && !ref_rise
      |=> bp_ph_q == $past(bp_ph_q) + $past(bp_inc))
      else $error("backplane rate wrong");
   co_rate_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      resetn |=> co_ph_q == $past(co_ph_q) + $past(co_inc))
      else $error("general clock rate wrong");
   bp_out_a : assert property (@(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> backplane_clock_out == $past(bp_ph_q[PH_W-1]))
      else $error("backplane pin not from phase");
endmodule // rctco_top

// *** sim/rctco_sink.sv ***
// partner model: backplane logic that clocks and samples receive timing
`timescale 1ns/100ps
module rctco_sink
   import rctco_pkg::*;
#(
   parameter int HALF = 5                // system clock half period
)(
   input  wire logic       clk_sys,      // system clock
   input  wire logic       run,          // system clock enable
   input  wire logic       tclk,         // clock timing the outputs
   input  wire logic [7:0] sig,          // serial signaling, all ports
   input  wire logic [7:0] pin,          // mask or channel clock pins
   output logic            sclk,         // receive system clock
   output logic            stb,          // capture strobe
   output logic [7:0]      cap_sig,      // sampled signaling
   output logic [7:0]      cap_pin       // sampled timing pins
);
   int   n;
   logic t_q;
   logic arm_q;
   // ==========================================================
   // system clock; stands still between frames
   always_ff @(posedge clk_sys)
   begin
      n    <= (!run || n == 2 * HALF - 1) ? 0 : n + 1;
      sclk <= run && (n < HALF);
   end
   // sample on the timing clock's fall, mid-period, far from updates
   always_ff @(posedge clk_sys)
   begin
      t_q     <= tclk;
      arm_q   <= run && (arm_q || (tclk && !t_q)); // no capture before a rise
      stb     <= arm_q && t_q && !tclk;
      cap_sig <= sig;
      cap_pin <= pin;
   end
endmodule // rctco_sink

// *** sim/rctco_top_bench.sv ***
// testbench: receive channel timing and clock outputs
`timescale 1ns/100ps
module rctco_top_bench
   import rctco_pkg::*;
;
   logic             clk_sys, resetn, run, lclk, sclk, stb;
   logic [3:0]       lc_n;
   logic [7:0]       cap_sig, cap_pin, es_en, e1m, chs, fs, sval;
   logic [7:0]       srdy, sig_o, tpin;
   logic [7:0][31:0] mask;
   logic [7:0][7:0]  sdat;
   logic [1:0]       bpf, bpr;
   logic [2:0]       cof;
   logic             epm, lfn, srch, txc, bpo, gco;
   int               err_total, comparisons;
   logic [7:0]       wq[$];
   // ==========================================================
   // design, all ports driven alike but for the block mask, so one model covers them
   rctco_top dut (.clk_sys(clk_sys), .resetn(resetn),
      .rx_recovered_line_clock({8{lclk}}), .rx_system_clock({8{sclk}}),
      .rx_es_enable(es_en), .rx_e1_mode(e1m), .rx_frame_start(fs),
      .rx_chclk_select(chs), .rx_block_mask(mask), .sig_in_data(sdat),
      .sig_in_valid(sval), .sig_in_ready(srdy), .rx_signaling_out(sig_o),
      .rx_channel_timing(tpin), .bp_freq_select(bpf), .bp_ref_select(bpr),
      .bp_ref_port(3'h0), .external_reference_clock(1'b0),
      .backplane_clock_out(bpo), .clock_out_freq_select(cof),
      .eight_port_mode_bit(epm), .loss_pin_function(lfn),
      .rx_frame_searching(srch), .tx_line_clock_in(txc),
      .general_clock_out(gco));
   rctco_sink #(.HALF(5)) sink (.clk_sys(clk_sys), .run(run),
      .tclk(es_en[0] ? sclk : lclk), .sig(sig_o), .pin(tpin),
      .sclk(sclk), .stb(stb), .cap_sig(cap_sig), .cap_pin(cap_pin));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // line clock, 8-cycle period against 10 for the system clock
   always @(posedge clk_sys)
   begin
      lc_n <= (!run || lc_n == 4'h7) ? 4'h0 : lc_n + 4'h1;
      lclk <= run && (lc_n < 4'h4);
   end
   // ==========================================================
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one frame after a reset; fifo filled to refusal first
   task automatic run_frame(input logic es, input logic e1, input logic cs);
      int         t;
      logic [7:0] w;
      logic [7:0] ep;
      @(posedge clk_sys);
      resetn <= 1'b0;
      run    <= 1'b0;
      es_en  <= {8{es}};
      e1m    <= {8{e1}};
      chs    <= {8{cs}};
      fs     <= 8'hff;
      for (int p = 0; p < 8; p++)
         mask[p] <= $urandom;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("sig_reset", sig_o, 8'h00);
      chk("pin_reset", tpin, 8'h00);
      @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      wq.delete();
      for (int i = 0; i < 9; i++)
      begin
         w = $urandom;
         if (i < 8)
            wq.push_back(w);
         sdat <= {8{w}};
         sval <= 8'hff;
         @(posedge clk_sys);
      end
      sval <= 8'h00;
      run  <= 1'b1;
      @(negedge clk_sys);
      chk("fifo_full", srdy, 8'h00);
      for (int k = 0; k < (e1 ? 256 : 192); k++)
      begin
         t = 0;
         do
         begin
            @(negedge clk_sys);
            t++;
         end while (stb !== 1'b1 && t < 40);
         chk("strobe", stb, 1'b1);
         // refused ninth word: channel 8 onward must carry zero
         w = (k / 8 < wq.size()) ? wq[k / 8] : 8'h00;
         chk("sig_bit", cap_sig, {8{w[7 - k % 8]}});
         for (int p = 0; p < 8; p++)
            ep[p] = cs ? (k % 8 == 7) : mask[p][k / 8];
         chk("timing_pin", cap_pin, ep);
         @(posedge clk_sys);
         fs <= 8'h00;
      end
   endtask
   // edge counts over 20 us; nco jitter allows two edges of slack
   task automatic clocks();
      int   ce, be, d;
      logic gq, bq;
      int   co_hz[8] = '{1544000, 2048000, 4096000, 8192000,
                         12288000, 16384000, 256000, 64000};
      int   bp_hz[4] = '{2048000, 4096000, 8192000, 16384000};
      for (int s = 0; s < 8; s++)
      begin
         @(posedge clk_sys);
         cof <= 3'(s);
         bpf <= 2'(s);
         bpr <= (s > 3) ? 2'h3 : 2'h2;
         repeat (50) @(posedge clk_sys);
         ce = 0;
         be = 0;
         gq = gco;
         bq = bpo;
         repeat (4000)
         begin
            @(negedge clk_sys);
            ce += (gco === 1'b1 && gq === 1'b0);
            be += (bpo === 1'b1 && bq === 1'b0);
            gq = gco;
            bq = bpo;
         end
         d = co_hz[s] / 50000 - ce;
         chk("co_rate", d * d <= 4, 1'b1);
         d = bp_hz[s % 4] / 50000 - be;
         chk("bp_rate", d * d <= 4, 1'b1);
      end
   endtask
   task automatic loss();
      @(posedge clk_sys);
      epm <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk_sys);
         srch <= $urandom;
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk("loss_frame", gco, srch);
      end
      @(posedge clk_sys);
      lfn <= 1'b1;
      repeat (60)
      begin
         repeat (5) @(posedge clk_sys);
         txc <= ~txc;
      end
      @(negedge clk_sys);
      chk("ltc_live", gco, 1'b0);
      repeat (370) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("ltc_early", gco, 1'b0);
      repeat (40) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("ltc_lost", gco, 1'b1);
      @(posedge clk_sys);
      txc <= ~txc;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("ltc_back", gco, 1'b0);
   endtask
   // ==========================================================
   initial
   begin
      resetn = 1'b0;
      run = 1'b0;
      {es_en, e1m, chs, fs, sval} = '0;
      mask = '0;
      sdat = '0;
      {bpf, bpr, cof, epm, lfn, srch, txc} = '0;
      err_total = 0;
      comparisons = 0;
      void'($urandom(32'h326284ae));
      run_frame(1'b0, 1'b0, 1'b0);
      run_frame(1'b1, 1'b1, 1'b1);
      clocks();
      loss();
      test_done();
   end
   // watchdog: the tests need about 180 us; stop at 400 us, 80k cycles, over twice that
   initial
   begin
      #400000;
      chk("watchdog", 1'b0, 1'b1);
      test_done();
   end
endmodule // rctco_top_bench
